// ---- hdl/dal_alu.sv ----
// operand select, add / add-with-carry / and / arithmetic shift datapath
module dal_alu
  import dal_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // operation from the decoder
  input  wire logic        op_valid,
  input  wire dal_op_t     op,
  input  wire logic        byte_mode,
  input  wire logic        to_default_file_operand_register,
  input  wire logic [12:0] f_addr,
  input  wire logic [9:0]  ten_bit_literal,
  input  wire logic [4:0]  five_bit_literal,
  input  wire logic [3:0]  acc_shift,
  input  wire logic        acc_sel,
  input  wire logic [3:0]  base_idx,
  input  wire logic [3:0]  src_idx,
  input  wire dal_am_t     src_mode,
  input  wire logic [3:0]  dst_idx,
  input  wire dal_am_t     dst_mode,
  input  wire logic [3:0]  mul_a,
  input  wire logic [3:0]  mul_b,
  // prefetch selection
  input  wire dal_pf_t     x_mode,
  input  wire logic        x_hi,
  input  wire logic [1:0]  x_step,
  input  wire logic        x_dec,
  input  wire logic [1:0]  x_dst,
  input  wire dal_pf_t     y_mode,
  input  wire logic        y_hi,
  input  wire logic [1:0]  y_step,
  input  wire logic        y_dec,
  input  wire logic [1:0]  y_dst,
  // data memory
  output logic      [15:0] mem_raddr,
  input  wire logic [15:0] mem_rdata,
  output logic             mem_we,
  output logic             mem_wbyte,
  output logic      [15:0] mem_waddr,
  output logic      [15:0] mem_wdata,
  output logic      [15:0] x_addr,
  output logic             x_rd,
  input  wire logic [15:0] x_rdata,
  output logic      [15:0] y_addr,
  output logic             y_rd,
  input  wire logic [15:0] y_rdata,
  // completion
  output logic             op_done,
  output logic             op_illegal,
  // register port
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_W-1:0][15:0] w;
    logic                   c, dc, n, ov, z;
    logic [ACC_W-1:0]       aa, ab;
    logic                   oa, ob, sa, sb;
    logic                   done, ill;
    logic [15:0]            rdata;
    logic                   we, wbyte;
    logic [15:0]            waddr, wdata;
  } dal_st_t;

  dal_st_t q, d;
  logic    rs1_b, rst_sync_b;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rs1_b      <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rs1_b      <= 1'b1;
      rst_sync_b <= rs1_b;
    end
  end

  // ----------------------------------------------------------------
  // prefetch channels: 0 is x space, 1 is y space
  // ----------------------------------------------------------------
  dal_pf_t     pm   [2];
  logic [3:0]  pr   [2];
  logic [1:0]  pst  [2];
  logic        pdec [2];
  logic [1:0]  pdst [2];
  logic        phi  [2];
  logic [15:0] pdat [2];
  logic [15:0] pa   [2];

  assign pm[0]   = x_mode;
  assign pm[1]   = y_mode;
  assign phi[0]  = x_hi;
  assign phi[1]  = y_hi;
  assign pr[0]   = x_hi ? W_X0 + 4'h1 : W_X0;
  assign pr[1]   = y_hi ? W_Y0 + 4'h1 : W_Y0;
  assign pst[0]  = x_step;
  assign pst[1]  = y_step;
  assign pdec[0] = x_dec;
  assign pdec[1] = y_dec;
  assign pdst[0] = x_dst;
  assign pdst[1] = y_dst;
  assign pdat[0] = x_rdata;
  assign pdat[1] = y_rdata;

  for (genvar k = 0; k < 2; k++)
  begin : g_pf
    assign pa[k] = (pm[k] == PF_OFF) ? q.w[pr[k]] + q.w[W_OFF] : q.w[pr[k]];
  end

  assign x_addr = pa[0];
  assign y_addr = pa[1];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] f_ea(input logic [15:0] r, input dal_am_t m,
                                       input logic [15:0] off, input logic [15:0] s);
    case (m)
      AM_PREINC:  f_ea = r + s;
      AM_PREDEC:  f_ea = r - s;
      AM_BASEOFF: f_ea = r + off;
      default:    f_ea = r;
    endcase
  endfunction

  function automatic logic [15:0] f_mod(input logic [15:0] r, input dal_am_t m,
                                        input logic [15:0] s);
    case (m)
      AM_POSTINC, AM_PREINC: f_mod = r + s;
      AM_POSTDEC, AM_PREDEC: f_mod = r - s;
      default:               f_mod = r;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  logic        f_form, l10, wf, l5, is_add, is_add_with_carry_op, is_and, asr1, asrn, pf_op, ill;
  logic        cin, msb_a, msb_b, msb_r, src_mem, acc_op, sa_set, sb_set;
  logic [15:0] stp, src_ea, dst_ea, srcv, opa, opb, r, nw;
  logic [16:0] s17;
  logic [8:0]  s9;
  logic [4:0]  s5, amt;
  logic [3:0]  mag;
  logic [ACC_W-1:0] ax, ay, av, asum;
  logic        ov40, ovf32;

  always_comb
  begin
    d       = q;
    d.done  = 1'b0;
    d.ill   = 1'b0;
    d.we    = 1'b0;
    d.rdata = '0;
    sa_set  = 1'b0;
    sb_set  = 1'b0;
    x_rd    = 1'b0;
    y_rd    = 1'b0;

    f_form  = op inside {OP_ADD_F, OP_ADD_WITH_CARRY_OP_F, OP_AND_F, OP_ASR_F};
    l10     = op inside {OP_ADD_L10, OP_ADD_WITH_CARRY_OP_L10, OP_AND_L10};
    wf      = op inside {OP_ADD_W, OP_ADD_WITH_CARRY_OP_W, OP_AND_W, OP_ASR_W};
    l5      = op inside {OP_ADD_L5, OP_ADD_WITH_CARRY_OP_L5, OP_AND_L5};
    is_add  = op inside {OP_ADD_F, OP_ADD_L10, OP_ADD_W, OP_ADD_L5};
    is_add_with_carry_op = op inside {OP_ADD_WITH_CARRY_OP_F, OP_ADD_WITH_CARRY_OP_L10, OP_ADD_WITH_CARRY_OP_W, OP_ADD_WITH_CARRY_OP_L5};
    is_and  = op inside {OP_AND_F, OP_AND_L10, OP_AND_W, OP_AND_L5};
    asr1    = op inside {OP_ASR_F, OP_ASR_W};
    asrn    = op inside {OP_ASR_WN, OP_ASR_L5};
    pf_op   = op inside {OP_MAC, OP_SQR};
    acc_op  = op inside {OP_ADD_ACC, OP_ADDS_ACC};

    // operand fetch
    stp     = byte_mode ? BYTE_STEP : WORD_STEP;
    src_ea  = f_ea(q.w[src_idx], src_mode, q.w[base_idx], stp);
    dst_ea  = f_ea(q.w[dst_idx], dst_mode, q.w[base_idx], stp);
    src_mem = (wf || op == OP_ADDS_ACC) && src_mode != AM_DIR;
    mem_raddr = f_form ? {3'b000, f_addr} : src_ea;
    srcv    = src_mem ? mem_rdata : q.w[src_idx];
    opa     = f_form ? mem_rdata : l10 ? q.w[dst_idx] : (op == OP_ASR_W) ? srcv : q.w[base_idx];
    opb     = f_form ? q.w[W_DEF] : l10 ? {6'h00, ten_bit_literal}
            : l5 ? {11'h000, five_bit_literal} : srcv;
    cin     = is_add_with_carry_op & q.c;

    // operand legality
    ill = 1'b0;
    if (l10 && byte_mode && ten_bit_literal > LIT_BYTE_MAX)
      ill = 1'b1;
    if ((wf && (src_mode == AM_BASEOFF || dst_mode == AM_BASEOFF)) || (acc_op && byte_mode))
      ill = 1'b1;
    if (asrn && (dst_mode != AM_DIR || (op == OP_ASR_WN && src_mode != AM_DIR)))
      ill = 1'b1;
    if (op == OP_DIV && (src_mode != AM_DIR || dst_mode != AM_DIR))
      ill = 1'b1;
    if (op == OP_SQR && (mul_a != mul_b || mul_a < W_MUL_LO || mul_a > W_MUL_HI))
      ill = 1'b1;
    if (op == OP_MAC && (mul_a == mul_b || mul_a < W_MUL_LO || mul_a > W_MUL_HI
                         || mul_b < W_MUL_LO || mul_b > W_MUL_HI))
      ill = 1'b1;
    if (pf_op && ((pm[0] == PF_OFF && !phi[0]) || (pm[1] == PF_OFF && !phi[1])))
      ill = 1'b1;

    // arithmetic, sized so byte flags come from the low byte
    s17   = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
    s9    = {1'b0, opa[7:0]} + {1'b0, opb[7:0]} + {8'h00, cin};
    s5    = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    amt   = (op == OP_ASR_WN) ? {1'b0, q.w[src_idx][3:0]} : five_bit_literal;
    r     = s17[15:0];
    if (is_and)
      r = opa & opb;
    else if (asr1)
      r = byte_mode ? {opa[15:8], opa[7], opa[7:1]} : {opa[15], opa[15:1]};
    else if (asrn)
      r = 16'($signed(opa) >>> amt);
    msb_a = byte_mode ? opa[7] : opa[15];
    msb_b = byte_mode ? opb[7] : opb[15];
    msb_r = byte_mode ? r[7] : r[15];
    nw    = byte_mode ? {q.w[dst_idx][15:8], r[7:0]} : r;

    // accumulator add, 16-bit value enters at the upper word
    mag  = acc_shift[3] ? 4'(-acc_shift) : acc_shift;
    av   = {{8{srcv[15]}}, srcv, 16'h0000};
    av   = acc_shift[3] ? av << mag : ACC_W'($signed(av) >>> mag);
    ax   = acc_sel ? q.ab : q.aa;
    ay   = (op == OP_ADD_ACC) ? (acc_sel ? q.aa : q.ab) : av;
    asum = ax + ay;
    ov40  = (ax[ACC_W-1] == ay[ACC_W-1]) && (asum[ACC_W-1] != ax[ACC_W-1]);
    ovf32 = !((&asum[ACC_W-1:31]) || !(|asum[ACC_W-1:31]));

    if (op_valid)
    begin
      d.done = 1'b1;
      d.ill  = ill;
    end

    if (op_valid && !ill)
    begin
      // address register side effects first, result write last
      if (src_mem && src_mode != AM_BASEOFF)
        d.w[src_idx] = f_mod(q.w[src_idx], src_mode, stp);
      if (wf && dst_mode != AM_DIR)
        d.w[dst_idx] = f_mod(q.w[dst_idx], dst_mode, stp);

      if (is_add || is_add_with_carry_op || is_and || asr1 || asrn)
      begin
        d.n = msb_r;
        d.z = byte_mode ? (r[7:0] == 8'h00) : (r == 16'h0000);
      end
      if (is_add || is_add_with_carry_op)
      begin
        d.c  = byte_mode ? s9[8] : s17[16];
        d.dc = byte_mode ? s5[4] : s9[8];
        d.ov = (msb_a == msb_b) && (msb_r != msb_a);
      end
      if (asr1)
      begin
        d.c  = opa[0];
        d.ov = 1'b0;
      end

      if (f_form)
      begin
        if (to_default_file_operand_register)
          d.w[W_DEF] = byte_mode ? {q.w[W_DEF][15:8], r[7:0]} : r;
        else
        begin
          d.we    = 1'b1;
          d.waddr = {3'b000, f_addr};
        end
      end
      else if (l10 || l5 || asrn || (wf && dst_mode == AM_DIR))
        d.w[dst_idx] = asrn ? r : nw;
      else if (wf)
      begin
        d.we    = 1'b1;
        d.waddr = dst_ea;
      end
      d.wdata = r;
      d.wbyte = byte_mode;

      if (acc_op)
      begin
        if (acc_sel)
        begin
          d.ab   = asum;
          d.ob   = ovf32;
          sb_set = ov40;
        end
        else
        begin
          d.aa   = asum;
          d.oa   = ovf32;
          sa_set = ov40;
        end
      end

      if (pf_op)
      begin
        for (int k = 0; k < 2; k++)
        begin
          if (pm[k] != PF_NONE)
          begin
            if (k == 0)
              x_rd = 1'b1;
            else
              y_rd = 1'b1;
            if (pm[k] == PF_MOD)
              d.w[pr[k]] = pdec[k] ? q.w[pr[k]] - {13'h0000, pst[k], 1'b0}
                                   : q.w[pr[k]] + {13'h0000, pst[k], 1'b0};
            d.w[W_PFD0 + {2'b00, pdst[k]}] = pdat[k];
          end
        end
      end
    end

    // register port: writes land after the operation, sticky sets survive
    if (reg_wr)
    begin
      if (reg_addr <= REG_W_LAST)
        d.w[reg_addr[3:0]] = reg_wdata;
      else if (reg_addr == REG_STATUS)
      begin
        d.c  = reg_wdata[ST_C];
        d.z  = reg_wdata[ST_Z];
        d.ov = reg_wdata[ST_OV];
        d.n  = reg_wdata[ST_N];
        d.dc = reg_wdata[ST_DC];
        d.sb = reg_wdata[ST_SB];
        d.sa = reg_wdata[ST_SA];
        d.ob = reg_wdata[ST_OB];
        d.oa = reg_wdata[ST_OA];
      end
    end
    d.sa = d.sa | sa_set;
    d.sb = d.sb | sb_set;

    if (reg_rd)
    begin
      if (reg_addr <= REG_W_LAST)
        d.rdata = q.w[reg_addr[3:0]];
      else if (reg_addr == REG_STATUS)
      begin
        d.rdata        = '0;
        d.rdata[ST_C]  = q.c;
        d.rdata[ST_Z]  = q.z;
        d.rdata[ST_OV] = q.ov;
        d.rdata[ST_N]  = q.n;
        d.rdata[ST_DC] = q.dc;
        d.rdata[ST_SB] = q.sb;
        d.rdata[ST_SA] = q.sa;
        d.rdata[ST_OB] = q.ob;
        d.rdata[ST_OA] = q.oa;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      q <= '0;
    else if (ce)
      q <= d;
  end

  assign op_done    = q.done;
  assign op_illegal = q.ill;
  assign reg_rdata  = q.rdata;
  assign mem_we     = q.we;
  assign mem_wbyte  = q.wbyte;
  assign mem_waddr  = q.waddr;
  assign mem_wdata  = q.wdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_sync_b);

  sequence s_go(dal_op_t o);
    op_valid && ce && op == o;
  endsequence

  sequence s_clean(dal_op_t o);
    s_go(o) ##0 (!ill && !reg_wr);
  endsequence

  a_one_cycle: assert property (op_valid && ce |=> op_done)
    else $error("operation not completed next cycle");
  a_sqr_pair: assert property (s_go(OP_SQR) ##0 (mul_a != mul_b) |=> op_illegal)
    else $error("unequal square pair accepted");
  a_mac_pair: assert property (s_go(OP_MAC) ##0 (mul_a == mul_b) |=> op_illegal)
    else $error("equal multiply pair accepted");
  a_div_direct: assert property (s_go(OP_DIV) ##0 (src_mode != AM_DIR) |=> op_illegal)
    else $error("indirect divide operand accepted");
  a_lit_range: assert property (s_go(OP_ADD_L10) ##0 (byte_mode && ten_bit_literal > LIT_BYTE_MAX)
                                |=> op_illegal)
    else $error("byte literal above 255 accepted");
  a_acc_flags: assert property (s_clean(OP_ADD_ACC) |=> $stable({q.c, q.dc, q.n, q.ov, q.z}))
    else $error("accumulator add changed core flags");
  a_and_flags: assert property (s_clean(OP_AND_W) |=> $stable({q.c, q.dc, q.ov}))
    else $error("and changed carry or overflow");
  a_asrn_flags: assert property (s_clean(OP_ASR_WN) |=> $stable({q.c, q.dc, q.ov}))
    else $error("shift by register changed C DC or OV");
  a_asr_sign: assert property (s_clean(OP_ASR_W) ##0 (dst_mode == AM_DIR && !byte_mode)
                               |=> q.w[$past(dst_idx)][15] == $past(opa[15]) && q.c == $past(opa[0]))
    else $error("single shift lost sign or carry");
  a_add_with_carry_op_carry: assert property (s_clean(OP_ADD_WITH_CARRY_OP_L10) ##0 (dst_mode == AM_DIR && !byte_mode)
                                 |=> q.w[$past(dst_idx)] == $past(s17[15:0]))
    else $error("literal add-with-carry result wrong");

endmodule

// ---- hdl/dal_pkg.sv ----
// constants and types shared by the operand select / add / shift datapath
package dal_pkg;

  // ----------------------------------------------------------------
  // datapath geometry
  // ----------------------------------------------------------------
  localparam int          DATA_W       = 16;
  localparam int          NUM_W        = 16;
  localparam int          ACC_W        = 40;
  localparam int          ACC_INS_LSB  = 16;
  localparam logic [15:0] WORD_STEP    = 16'h0002;
  localparam logic [15:0] BYTE_STEP    = 16'h0001;
  localparam logic [9:0]  LIT_BYTE_MAX = 10'h0ff;

  // ----------------------------------------------------------------
  // fixed working register roles
  // ----------------------------------------------------------------
  localparam logic [3:0] W_DEF  = 4'h0;
  localparam logic [3:0] W_PFD0 = 4'h4;
  localparam logic [3:0] W_X0   = 4'h8;
  localparam logic [3:0] W_Y0   = 4'ha;
  localparam logic [3:0] W_OFF  = 4'hc;
  localparam logic [3:0] W_MUL_LO = 4'h4;
  localparam logic [3:0] W_MUL_HI = 4'h7;

  // ----------------------------------------------------------------
  // register port map and status layout
  // ----------------------------------------------------------------
  localparam logic [4:0]  REG_W_LAST = 5'h0f;
  localparam logic [4:0]  REG_STATUS = 5'h10;
  localparam int          ST_C   = 0;
  localparam int          ST_Z   = 1;
  localparam int          ST_OV  = 2;
  localparam int          ST_N   = 3;
  localparam int          ST_DC  = 8;
  localparam int          ST_SB  = 12;
  localparam int          ST_SA  = 13;
  localparam int          ST_OB  = 14;
  localparam int          ST_OA  = 15;
  localparam logic [15:0] W_RST  = 16'h0000;
  localparam logic [39:0] ACC_RST = 40'h00_0000_0000;

  // ----------------------------------------------------------------
  // operations, addressing modes, prefetch modes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP, OP_ADD_ACC, OP_ADDS_ACC,
    OP_ADD_F, OP_ADD_L10, OP_ADD_W, OP_ADD_L5,
    OP_ADD_WITH_CARRY_OP_F, OP_ADD_WITH_CARRY_OP_L10, OP_ADD_WITH_CARRY_OP_W, OP_ADD_WITH_CARRY_OP_L5,
    OP_AND_F, OP_AND_L10, OP_AND_W, OP_AND_L5,
    OP_ASR_F, OP_ASR_W, OP_ASR_WN, OP_ASR_L5,
    OP_MAC, OP_SQR, OP_DIV
  } dal_op_t;

  typedef enum logic [2:0] {
    AM_DIR, AM_IND, AM_POSTINC, AM_POSTDEC, AM_PREINC, AM_PREDEC, AM_BASEOFF
  } dal_am_t;

  typedef enum logic [1:0] {PF_NONE, PF_KEEP, PF_MOD, PF_OFF} dal_pf_t;

endpackage

// ---- test/dal_mem_model.sv ----
// data space and prefetch port model facing the datapath
module dal_mem_model
(
  // clock
  input  wire logic        clock,
  // data memory
  input  wire logic [15:0] mem_raddr,
  output logic      [15:0] mem_rdata,
  input  wire logic        mem_we,
  input  wire logic        mem_wbyte,
  input  wire logic [15:0] mem_waddr,
  input  wire logic [15:0] mem_wdata,
  // prefetch ports
  input  wire logic [15:0] x_addr,
  input  wire logic        x_rd,
  output logic      [15:0] x_rdata,
  input  wire logic [15:0] y_addr,
  input  wire logic        y_rd,
  output logic      [15:0] y_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] mem [256];

  initial foreach (mem[i]) mem[i] = 16'h0000;

  // combinational read, as the datapath samples data in the request cycle
  assign mem_rdata = mem[mem_raddr[8:1]];
  // an idle port shows the inverted address, so a stale word never looks valid
  assign x_rdata = x_rd ? mem[x_addr[8:1]] : ~x_addr;
  assign y_rdata = y_rd ? mem[y_addr[8:1]] : ~y_addr;

  always @(posedge clock)
  begin
    if (mem_we && mem_wbyte && mem_waddr[0])
      mem[mem_waddr[8:1]][15:8] <= mem_wdata[7:0];
    else if (mem_we && mem_wbyte)
      mem[mem_waddr[8:1]][7:0] <= mem_wdata[7:0];
    else if (mem_we)
      mem[mem_waddr[8:1]] <= mem_wdata;
  end
endmodule

// ---- test/test_dal_alu.sv ----
// self-checking bench for the operand select / add / shift datapath
module test_dal_alu;
  import dal_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clock, rst_b, ce, op_valid, byte_mode, to_default_file_operand_register, acc_sel, x_hi, x_dec, y_hi, y_dec;
  dal_op_t op;
  dal_am_t src_mode, dst_mode;
  dal_pf_t x_mode, y_mode;
  logic [12:0] f_addr;
  logic [9:0]  ten_bit_literal;
  logic [4:0]  five_bit_literal, reg_addr;
  logic [3:0]  acc_shift, base_idx, src_idx, dst_idx, mul_a, mul_b;
  logic [1:0]  x_step, x_dst, y_step, y_dst;
  logic [15:0] mem_raddr, mem_rdata, mem_waddr, mem_wdata, x_addr, x_rdata, y_addr, y_rdata;
  logic        mem_we, mem_wbyte, x_rd, y_rd, op_done, op_illegal, reg_wr, reg_rd;
  logic [15:0] reg_wdata, reg_rdata, got, xa, ya, wa, wd;
  logic        xr, yr, wv;
  int          errors = 0;
  int          checks = 0;

  typedef struct {
    dal_op_t op; logic bm; logic [9:0] l10; logic [4:0] l5;
    logic [15:0] wb, ws, wd, st0, exp, sexp; logic ill;
  } dal_row_t;

  // base W5, source W6, destination W2 in every row
  dal_row_t rows[15] = '{
    '{OP_ADD_WITH_CARRY_OP_L10, 1'b0, 10'h005, 5'h00, 16'h0000, 16'h0000, 16'h0010, 16'h0001, 16'h0016, 16'h0000, 1'b0},
    '{OP_ADD_WITH_CARRY_OP_L10, 1'b0, 10'h001, 5'h00, 16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0000, 16'h0103, 1'b0},
    '{OP_ADD_W,    1'b0, 10'h000, 5'h00, 16'h7fff, 16'h0001, 16'h0000, 16'h0000, 16'h8000, 16'h010c, 1'b0},
    '{OP_ADD_WITH_CARRY_OP_W,   1'b0, 10'h000, 5'h00, 16'h1234, 16'h0100, 16'h0000, 16'h0001, 16'h1335, 16'h0000, 1'b0},
    '{OP_AND_W,    1'b0, 10'h000, 5'h00, 16'hf0f0, 16'h8f00, 16'h0000, 16'h0105, 16'h8000, 16'h010d, 1'b0},
    '{OP_ASR_W,    1'b0, 10'h000, 5'h00, 16'h0000, 16'h8001, 16'h0000, 16'h0104, 16'hc000, 16'h0109, 1'b0},
    '{OP_ASR_WN,   1'b0, 10'h000, 5'h00, 16'h8000, 16'h0004, 16'h0000, 16'h0105, 16'hf800, 16'h010d, 1'b0},
    '{OP_ASR_L5,   1'b0, 10'h000, 5'h0f, 16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'h0008, 1'b0},
    '{OP_ADD_L5,   1'b0, 10'h000, 5'h1f, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0020, 16'h0000, 1'b0},
    '{OP_AND_L10,  1'b0, 10'h3ff, 5'h00, 16'h0000, 16'h0000, 16'h0400, 16'h0001, 16'h0000, 16'h0003, 1'b0},
    '{OP_ADD_WITH_CARRY_OP_L10, 1'b1, 10'h100, 5'h00, 16'h0000, 16'h0000, 16'h1234, 16'h0001, 16'h1234, 16'h0001, 1'b1},
    '{OP_ADD_L10,  1'b1, 10'h0ff, 5'h00, 16'h0000, 16'h0000, 16'h1201, 16'h0000, 16'h1200, 16'h0103, 1'b0},
    '{OP_ADD_ACC,  1'b0, 10'h000, 5'h00, 16'h0000, 16'h0000, 16'h5555, 16'h010f, 16'h5555, 16'h010f, 1'b0},
    '{OP_ADDS_ACC, 1'b0, 10'h000, 5'h00, 16'h0000, 16'h7fff, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0},
    '{OP_ADDS_ACC, 1'b0, 10'h000, 5'h00, 16'h0000, 16'h7fff, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 1'b0}
  };

  dal_alu dut (.clock, .rst_b, .ce, .op_valid, .op, .byte_mode, .to_default_file_operand_register, .f_addr, .ten_bit_literal,
    .five_bit_literal, .acc_shift, .acc_sel, .base_idx, .src_idx, .src_mode, .dst_idx, .dst_mode, .mul_a,
    .mul_b, .x_mode, .x_hi, .x_step, .x_dec, .x_dst, .y_mode, .y_hi, .y_step, .y_dec, .y_dst, .mem_raddr,
    .mem_rdata, .mem_we, .mem_wbyte, .mem_waddr, .mem_wdata, .x_addr, .x_rd, .x_rdata, .y_addr, .y_rd,
    .y_rdata, .op_done, .op_illegal, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  dal_mem_model mdl (.clock, .mem_raddr, .mem_rdata, .mem_we, .mem_wbyte, .mem_waddr, .mem_wdata,
    .x_addr, .x_rd, .x_rdata, .y_addr, .y_rd, .y_rdata);

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk_val(input logic [15:0] g, input logic [15:0] e, input string m);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e, input string m);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %0t %s got %b exp %b", $time, m, g, e);
    end
  endtask

  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // caller sets the operand fields at the same edge
  task automatic run_op(input dal_op_t o, input logic ill);
    op_valid <= 1'b1;
    op       <= o;
    #1;
    xa = x_addr;
    ya = y_addr;
    xr = x_rd;
    yr = y_rd;
    @(posedge clock);
    op_valid <= 1'b0;
    op       <= OP_NOP;
    #1;
    chk_bit(op_done, 1'b1, "op done");
    chk_bit(op_illegal, ill, "op illegal");
    wv = mem_we;
    wa = mem_waddr;
    wd = mem_wdata;
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // the whole run takes a few hundred cycles
  initial
  begin
    #(20000 * 8);
    errors++;
    wrap_up;
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    {ce, op_valid, byte_mode, to_default_file_operand_register, acc_sel, x_hi, x_dec, y_hi, y_dec, reg_wr, reg_rd} = '0;
    ce = 1'b1;
    op = OP_NOP;
    src_mode = AM_DIR;
    dst_mode = AM_DIR;
    x_mode   = PF_NONE;
    y_mode   = PF_NONE;
    {f_addr, ten_bit_literal, five_bit_literal, acc_shift, mul_a, mul_b} = '0;
    {x_step, x_dst, y_step, y_dst, reg_addr, reg_wdata} = '0;
    {base_idx, src_idx, dst_idx} = {4'h5, 4'h6, 4'h2};
    rst_b = 1'b0;
    repeat (16) @(posedge clock);
    #1;
    chk_bit(op_done, 1'b0, "done in reset");
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 18; i++)
    begin
      reg_read(i[4:0], got);
      chk_val(got, 16'h0000, "reset value");
    end
    for (int i = 0; i < 16; i++)
      reg_write(i[4:0], 16'h1111 * i[15:0]);
    for (int i = 0; i < 16; i++)
    begin
      reg_read(i[4:0], got);
      chk_val(got, 16'h1111 * i[15:0], "w file");
    end
    reg_write(5'h11, 16'hffff);
    reg_read(5'h11, got);
    chk_val(got, 16'h0000, "unmapped");
    reg_write(REG_STATUS, 16'hffff);
    reg_read(REG_STATUS, got);
    chk_val(got, 16'hf10f, "status bits");
    $display("register test done");

    foreach (rows[i])
    begin
      reg_write(5'h05, rows[i].wb);
      reg_write(5'h06, rows[i].ws);
      reg_write(5'h02, rows[i].wd);
      reg_write(REG_STATUS, rows[i].st0);
      @(posedge clock);
      byte_mode        <= rows[i].bm;
      ten_bit_literal  <= rows[i].l10;
      five_bit_literal <= rows[i].l5;
      run_op(rows[i].op, rows[i].ill);
      reg_read(5'h02, got);
      chk_val(got, rows[i].exp, "result");
      reg_read(REG_STATUS, got);
      chk_val(got & 16'hf10f, rows[i].sexp, "flags");
      $display("row %0d done", i);
    end
    byte_mode <= 1'b0;

    // file form: W0 is the second operand and the other destination
    mdl.mem[8'h10] = 16'h0100;
    reg_write(5'h00, 16'h0011);
    reg_write(REG_STATUS, 16'h0001);
    @(posedge clock);
    f_addr  <= 13'h0020;
    to_default_file_operand_register <= 1'b1;
    run_op(OP_ADD_WITH_CARRY_OP_F, 1'b0);
    chk_bit(wv, 1'b0, "no mem write");
    reg_read(5'h00, got);
    chk_val(got, 16'h0112, "f to w0");
    @(posedge clock);
    to_default_file_operand_register <= 1'b0;
    run_op(OP_ADD_WITH_CARRY_OP_F, 1'b0);
    chk_bit(wv, 1'b1, "mem write");
    chk_val(wa, 16'h0020, "f addr");
    chk_val(wd, 16'h0212, "f data");
    $display("file test done");

    // indirect destination with post increment, then refused base offset
    reg_write(5'h05, 16'h0003);
    reg_write(5'h06, 16'h0004);
    reg_write(5'h02, 16'h0040);
    @(posedge clock);
    dst_mode <= AM_POSTINC;
    run_op(OP_ADD_W, 1'b0);
    chk_val({15'h0000, wv}, 16'h0001, "ind write");
    chk_val(wa, 16'h0040, "ind addr");
    chk_val(wd, 16'h0007, "ind data");
    @(posedge clock);
    dst_mode <= AM_BASEOFF;
    run_op(OP_ADD_W, 1'b1);
    reg_read(5'h02, got);
    chk_val(got, 16'h0042, "post inc");
    @(posedge clock);
    dst_mode <= AM_DIR;
    run_op(OP_DIV, 1'b0);
    @(posedge clock);
    src_mode <= AM_IND;
    run_op(OP_DIV, 1'b1);
    @(posedge clock);
    src_mode <= AM_DIR;
    // clock enable low: the operation must leave no trace
    @(posedge clock);
    ce       <= 1'b0;
    op_valid <= 1'b1;
    op       <= OP_ADD_L5;
    @(posedge clock);
    op_valid <= 1'b0;
    op       <= OP_NOP;
    ce       <= 1'b1;
    #1;
    chk_bit(op_done, 1'b0, "frozen done");
    reg_read(5'h02, got);
    chk_val(got, 16'h0042, "frozen w");
    $display("addressing test done");

    for (int a = 3; a < 8; a++)
      for (int b = 4; b < 8; b++)
      begin
        @(posedge clock);
        mul_a <= a[3:0];
        mul_b <= b[3:0];
        run_op(OP_SQR, !(a == b));
        @(posedge clock);
        run_op(OP_MAC, !(a != b && a > 3));
      end
    $display("pair test done");

    // x post-modify +6 from W8 into W4, y from W11+W12 into W5
    mdl.mem[8'h40] = 16'hbeef;
    mdl.mem[8'h4a] = 16'h1357;
    reg_write(5'h08, 16'h0080);
    reg_write(5'h0b, 16'h0090);
    reg_write(5'h0c, 16'h0004);
    @(posedge clock);
    mul_a  <= 4'h4;
    mul_b  <= 4'h5;
    x_mode <= PF_MOD;
    x_step <= 2'h3;
    x_dst  <= 2'h0;
    y_mode <= PF_OFF;
    y_hi   <= 1'b1;
    y_dst  <= 2'h1;
    run_op(OP_MAC, 1'b0);
    chk_val(xa, 16'h0080, "x addr");
    chk_val(ya, 16'h0094, "y addr");
    chk_bit(xr & yr, 1'b1, "prefetch rd");
    reg_read(5'h04, got);
    chk_val(got, 16'hbeef, "x data");
    reg_read(5'h05, got);
    chk_val(got, 16'h1357, "y data");
    reg_read(5'h08, got);
    chk_val(got, 16'h0086, "x modify");
    @(posedge clock);
    x_mode <= PF_OFF;
    y_mode <= PF_NONE;
    run_op(OP_MAC, 1'b1);
    $display("prefetch test done");
    wrap_up;
  end
endmodule
